// ===== core/shift_unit_pkg.sv
package shift_unit_pkg;

    // shift opcodes as seen by the decoder
    localparam logic [7:0] OP_WORD_LEFT    = 8'h09;
    localparam logic [7:0] OP_BYTE_LEFT    = 8'h19;
    localparam logic [7:0] OP_DWORD_LEFT   = 8'h0d;
    localparam logic [7:0] OP_WORD_LRIGHT  = 8'h08;
    localparam logic [7:0] OP_BYTE_LRIGHT  = 8'h18;
    localparam logic [7:0] OP_DWORD_LRIGHT = 8'h0c;
    localparam logic [7:0] OP_WORD_ARIGHT  = 8'h0a;
    localparam logic [7:0] OP_BYTE_ARIGHT  = 8'h1a;
    localparam logic [7:0] OP_DWORD_ARIGHT = 8'h0e;

    // count byte: below this it is an immediate, else a register address
    localparam logic [7:0] REG_COUNT_BASE  = 8'h10;
    localparam int         IMM_COUNT_BITS  = 4;
    localparam int         REG_COUNT_BITS  = 5;

    // wishbone register byte offsets
    localparam int         ADDR_BITS       = 8;
    localparam logic [7:0] ADDR_OPCODE     = 8'h00;
    localparam logic [7:0] ADDR_COUNT      = 8'h04;
    localparam logic [7:0] ADDR_OPERAND    = 8'h08;
    localparam logic [7:0] ADDR_CONTROL    = 8'h0c;
    localparam logic [7:0] ADDR_PSW        = 8'h10;
    localparam logic [7:0] ADDR_RESULT     = 8'h14;
    localparam logic [7:0] ADDR_STATUS     = 8'h18;

    // field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLRERR_BIT = 1;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_ERR_BIT   = 1;
    localparam int PSW_Z_BIT      = 7;
    localparam int PSW_N_BIT      = 6;
    localparam int PSW_V_BIT      = 5;
    localparam int PSW_VT_BIT     = 4;
    localparam int PSW_C_BIT      = 3;
    localparam int PSW_STICKY_BIT = 0;

    // reset values
    localparam logic [7:0]  OPCODE_RESET  = 8'h00;
    localparam logic [7:0]  COUNT_RESET   = 8'h00;
    localparam logic [31:0] OPERAND_RESET = 32'h0000_0000;
    localparam logic [7:0]  PSW_RESET     = 8'h00;

    typedef enum logic [1:0] {KIND_LEFT, KIND_LRIGHT, KIND_ARIGHT} shiftKind_t;
    typedef enum logic [1:0] {WIDTH_BYTE, WIDTH_WORD, WIDTH_DWORD} opWidth_t;
    typedef enum logic [1:0] {IDLE, FETCH_COUNT, STEP, FINISH} unitState_t;

    typedef struct packed {
        logic       legal;
        shiftKind_t kind;
        opWidth_t   width;
    } opDecode_t;

endpackage : shift_unit_pkg

// ===== core/shift_unit_datapath.sv
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
// Function
// - an immediate count of 0 to 15 is accepted for every shift kind and width.
// - a count may come from a register at address 10h or above, holding 0 to 31.
// - left shifts bring a zero into the low end on each step.
// - logical right shifts bring a zero into the top end, an unsigned halving per step.
// - arithmetic right shifts replicate the original top bit, a signed halving per step.
// - after a shift of one or more steps the carry flag holds the last bit shifted out; a zero count keeps carry.
// - a left shift copies the top bit into carry before each step until the count is zero.
// - every right shift clears the sticky flag at its start.
// - a right shift sets sticky when carry holds a one shifted out by this shift and another step follows.
// - byte, word and double-word widths are supported for all three shift kinds.
// - opcodes 09h, 19h and 0dh decode as word, byte and double-word left shifts.
// - opcodes 08h, 18h and 0ch decode as word, byte and double-word logical right shifts.
// - opcodes 0ah, 1ah and 0eh decode as word, byte and double-word arithmetic right shifts.
// - right shifts update zero and carry, clear overflow, keep the trap flag; negative is cleared by logical, takes the top bit on arithmetic.
module shift_unit_datapath
    import shift_unit_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [ADDR_BITS-1:0] wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // register file count read port
    output logic      [7:0]           regRdAddr,
    input  wire logic [7:0]           regRdData,
    // result towards the register file
    output logic      [31:0]          resultData,
    output logic                      resultValid,
    output logic      [7:0]           pswOut,
    output logic                      busy
);

    // opcode decoding, shared by the start check and the status view
    function automatic opDecode_t decodeOp(input logic [7:0] op);
        opDecode_t d;
        d = '{legal: 1'b1, kind: KIND_LEFT, width: WIDTH_WORD};
        case (op)
            OP_WORD_LEFT:    d = '{1'b1, KIND_LEFT,   WIDTH_WORD};
            OP_BYTE_LEFT:    d = '{1'b1, KIND_LEFT,   WIDTH_BYTE};
            OP_DWORD_LEFT:   d = '{1'b1, KIND_LEFT,   WIDTH_DWORD};
            OP_WORD_LRIGHT:  d = '{1'b1, KIND_LRIGHT, WIDTH_WORD};
            OP_BYTE_LRIGHT:  d = '{1'b1, KIND_LRIGHT, WIDTH_BYTE};
            OP_DWORD_LRIGHT: d = '{1'b1, KIND_LRIGHT, WIDTH_DWORD};
            OP_WORD_ARIGHT:  d = '{1'b1, KIND_ARIGHT, WIDTH_WORD};
            OP_BYTE_ARIGHT:  d = '{1'b1, KIND_ARIGHT, WIDTH_BYTE};
            OP_DWORD_ARIGHT: d = '{1'b1, KIND_ARIGHT, WIDTH_DWORD};
            default:         d = '{1'b0, KIND_LEFT,   WIDTH_WORD};
        endcase
        return d;
    endfunction : decodeOp

    // bits that belong to an operand of the given width
    function automatic logic [31:0] widthMask(input opWidth_t w);
        case (w)
            WIDTH_BYTE:  return 32'h0000_00ff;
            WIDTH_WORD:  return 32'h0000_ffff;
            default:     return 32'hffff_ffff;
        endcase
    endfunction : widthMask

    // one-hot top bit of the given width
    function automatic logic [31:0] topBit(input opWidth_t w);
        case (w)
            WIDTH_BYTE:  return 32'h0000_0080;
            WIDTH_WORD:  return 32'h0000_8000;
            default:     return 32'h8000_0000;
        endcase
    endfunction : topBit

    // software-visible configuration
    logic [7:0]  opcode;
    logic [7:0]  countByte;
    logic [31:0] operand;
    logic [7:0]  processor_status_word;
    logic        opError;

    // working state of one shift
    unitState_t  state;
    shiftKind_t  workKind;
    opWidth_t    workWidth;
    logic [31:0] work;
    logic [4:0]  remaining;
    logic        workCarry;
    logic        workSticky;
    logic        workOvf;
    logic        carryFresh;  // carry was loaded by this shift, not left over

    // bus decode
    logic        busReq;
    logic        busWrite;
    logic        startReq;
    opDecode_t   startDec;
    logic        workMsb;
    logic [31:0] stepLeft;
    logic [31:0] stepRight;
    logic [31:0] readMux;

    assign busReq   = wb_cyc_i & wb_stb_i;
    // writes land at the edge where the master sees ack, as classic wishbone expects
    assign busWrite = busReq & wb_we_i & wb_ack_o;
    assign startReq = busWrite & (wb_adr_i == ADDR_CONTROL) & wb_sel_i[0]
                      & wb_dat_i[CTRL_START_BIT];
    assign startDec = decodeOp(opcode);
    assign workMsb  = |(work & topBit(workWidth));
    assign stepLeft = (work << 1) & widthMask(workWidth);
    // arithmetic fill reuses the current top bit, which always equals the original one
    assign stepRight = (work >> 1)
                       | ((workKind == KIND_ARIGHT && workMsb) ? topBit(workWidth)
                                                               : 32'h0000_0000);

    // read multiplexer, unmapped offsets read as zero
    always_comb begin
        readMux = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_OPCODE:  readMux = {24'h00_0000, opcode};
            ADDR_COUNT:   readMux = {24'h00_0000, countByte};
            ADDR_OPERAND: readMux = operand;
            ADDR_PSW:     readMux = {24'h00_0000, processor_status_word};
            ADDR_RESULT:  readMux = resultData;
            ADDR_STATUS:  readMux = {30'h0000_0000, opError, busy};
            default:      readMux = 32'h0000_0000;
        endcase
    end

    // single wait-state ack, dropped the cycle after it was given
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq & ~wb_ack_o;
            if (busReq & ~wb_ack_o) begin
                wb_dat_o <= readMux;
            end
        end
    end

    // opcode and count byte registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            opcode    <= OPCODE_RESET;
            countByte <= COUNT_RESET;
        end else if (busWrite && wb_sel_i[0]) begin
            if (wb_adr_i == ADDR_OPCODE) begin
                opcode <= wb_dat_i[7:0];
            end
            if (wb_adr_i == ADDR_COUNT) begin
                countByte <= wb_dat_i[7:0];
            end
        end
    end

    // operand register with byte lanes; the running shift works on its own copy
    always_ff @(posedge clk) begin
        if (!nrst) begin
            operand <= OPERAND_RESET;
        end else if (busWrite && wb_adr_i == ADDR_OPERAND) begin
            for (int i = 0; i < 4; i++) begin
                if (wb_sel_i[i]) begin
                    operand[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                end
            end
        end
    end

    // illegal opcode flag: a new error wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            opError <= 1'b0;
        end else if (startReq && state == IDLE && !startDec.legal) begin
            opError <= 1'b1;
        end else if (busWrite && wb_adr_i == ADDR_CONTROL && wb_sel_i[0]
                     && wb_dat_i[CTRL_CLRERR_BIT]) begin
            opError <= 1'b0;
        end
    end

    // sequencer: one shift step per clock, a start while busy is ignored
    // the count is captured at start, so later writes to it only affect the next shift
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state      <= IDLE;
            workKind   <= KIND_LEFT;
            workWidth  <= WIDTH_WORD;
            work       <= 32'h0000_0000;
            remaining  <= 5'h00;
            workCarry  <= 1'b0;
            workSticky <= 1'b0;
            workOvf    <= 1'b0;
            carryFresh <= 1'b0;
            regRdAddr  <= 8'h00;
        end else begin
            case (state)
                IDLE: begin
                    if (startReq && startDec.legal) begin
                        workKind   <= startDec.kind;
                        workWidth  <= startDec.width;
                        work       <= operand & widthMask(startDec.width);
                        workCarry  <= processor_status_word[PSW_C_BIT];  // zero count keeps carry
                        workSticky <= 1'b0;
                        workOvf    <= 1'b0;
                        // a carry left by an earlier instruction must not feed sticky
                        carryFresh <= 1'b0;
                        if (countByte < REG_COUNT_BASE) begin
                            remaining <= {1'b0, countByte[IMM_COUNT_BITS-1:0]};
                            state     <= STEP;
                        end else begin
                            regRdAddr <= countByte;
                            state     <= FETCH_COUNT;
                        end
                    end
                end
                FETCH_COUNT: begin
                    // the register file answers in the same cycle, so one fetch cycle is enough
                    // upper bits of the count register are ignored
                    remaining <= regRdData[REG_COUNT_BITS-1:0];
                    state     <= STEP;
                end
                STEP: begin
                    if (remaining == 5'h00) begin
                        state <= FINISH;
                    end else begin
                        remaining <= remaining - 5'h01;
                        carryFresh <= 1'b1;
                        if (workKind == KIND_LEFT) begin
                            workCarry <= workMsb;
                            work      <= stepLeft;
                            if (workMsb != |(stepLeft & topBit(workWidth))) begin
                                workOvf <= 1'b1;
                            end
                        end else begin
                            workCarry <= work[0];
                            work      <= stepRight;
                            // a one shifted into carry by this shift, then another step
                            if (workCarry && carryFresh) begin
                                workSticky <= 1'b1;
                            end
                        end
                    end
                end
                FINISH: begin
                    state <= IDLE;
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    // status word: finishing shift wins over a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            processor_status_word <= PSW_RESET;
        end else if (state == FINISH) begin
            processor_status_word[PSW_Z_BIT] <= (work == 32'h0000_0000);
            processor_status_word[PSW_C_BIT] <= workCarry;
            processor_status_word[PSW_N_BIT] <= (workKind == KIND_LRIGHT) ? 1'b0 : workMsb;
            processor_status_word[PSW_V_BIT] <= (workKind == KIND_LEFT) ? workOvf : 1'b0;
            if (workKind != KIND_LEFT) begin
                processor_status_word[PSW_STICKY_BIT] <= workSticky;
            end
        end else if (busWrite && wb_adr_i == ADDR_PSW && wb_sel_i[0]) begin
            processor_status_word <= wb_dat_i[7:0];
        end
    end

    // result hand-off and outward status
    always_ff @(posedge clk) begin
        if (!nrst) begin
            resultData  <= 32'h0000_0000;
            resultValid <= 1'b0;
            busy        <= 1'b0;
        end else begin
            resultValid <= (state == FINISH);
            if (state == FINISH) begin
                resultData <= work;
            end
            // busy rises with the accepted start and falls as the result is handed off
            if (state == IDLE) begin
                busy <= startReq & startDec.legal;
            end else begin
                busy <= (state != FINISH);
            end
        end
    end

    assign pswOut = processor_status_word;

endmodule : shift_unit_datapath

// ===== verif/shift_unit_datapath_properties.sv
`timescale 1ns/100ps
// watches the shift unit from its ports only
module shift_unit_datapath_checker
    import shift_unit_pkg::*;
(
    // clock and reset
    input wire logic                 clk,
    input wire logic                 nrst,
    // wishbone
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [ADDR_BITS-1:0] wb_adr_i,
    input wire logic [3:0]           wb_sel_i,
    input wire logic [31:0]          wb_dat_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    // count port and result
    input wire logic [7:0]           regRdAddr,
    input wire logic [7:0]           regRdData,
    input wire logic [31:0]          resultData,
    input wire logic                 resultValid,
    input wire logic [7:0]           pswOut,
    input wire logic                 busy
);
    logic [7:0] opc, cnt, runOp, runCnt;
    logic [5:0] el;
    logic       wrOk, go, legal;

    // a write lands at the edge where ack is sampled high; start is ignored while busy
    assign wrOk  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign go    = wrOk && wb_adr_i == ADDR_CONTROL && wb_dat_i[CTRL_START_BIT] && !busy;
    assign legal = opc inside {[8'h08:8'h0a], [8'h0c:8'h0e], [8'h18:8'h1a]};

    // shadow of opcode and count, frozen at start, plus cycles since start
    always_ff @(posedge clk) begin
        if (!nrst) begin
            opc    <= 8'h00;
            cnt    <= 8'h00;
            runOp  <= 8'h00;
            runCnt <= 8'h00;
            el     <= 6'h00;
        end else begin
            if (wrOk && wb_adr_i == ADDR_OPCODE) opc <= wb_dat_i[7:0];
            if (wrOk && wb_adr_i == ADDR_COUNT) cnt <= wb_dat_i[7:0];
            runOp  <= go ? opc : runOp;
            runCnt <= go ? cnt : runCnt;
            el     <= go ? 6'h00 : el + 6'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_IMM_LATENCY: assert property (resultValid && runCnt < REG_COUNT_BASE |->
        el == runCnt[3:0] + 6'h02) else $error("immediate shift took wrong time");
    AST_REG_ADDR: assert property (go && legal && cnt >= REG_COUNT_BASE |->
        ##2 regRdAddr == runCnt) else $error("count register address wrong");
    AST_BUSY_START: assert property (go && legal |-> ##[1:2] busy)
        else $error("shift opcode did not start");
    AST_ZERO_FLAG: assert property (resultValid |->
        pswOut[PSW_Z_BIT] == (resultData == 0)) else $error("zero flag wrong");
    AST_RIGHT_V: assert property (resultValid && !runOp[0] |-> !pswOut[PSW_V_BIT])
        else $error("overflow left set on right shift");
    AST_LOGIC_N: assert property (resultValid && runOp[1:0] == 2'b00 |->
        !pswOut[PSW_N_BIT]) else $error("negative left set on logical shift");
    AST_BYTE_WIDTH: assert property (resultValid && runOp[4] |-> resultData[31:8] == 0)
        else $error("byte result wider than a byte");
    AST_WORD_WIDTH: assert property (resultValid && !runOp[4] && !runOp[2] |->
        resultData[31:16] == 0) else $error("word result wider than a word");
    AST_VT_KEEP: assert property (resultValid |->
        pswOut[PSW_VT_BIT] == $past(pswOut[PSW_VT_BIT])) else $error("trap flag changed by shift");

    cover property (go && legal && cnt < REG_COUNT_BASE);
    cover property (go && legal && cnt >= REG_COUNT_BASE);
    cover property (resultValid && runOp[4]);
endmodule : shift_unit_datapath_checker

bind shift_unit_datapath shift_unit_datapath_checker props (
    .clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .regRdAddr, .regRdData, .resultData, .resultValid,
    .pswOut, .busy
);

// ===== verif/count_reg_file_model.sv
`timescale 1ns/100ps
// register file read port as the count fetch sees it
module count_reg_file_model (
    // read port
    input  wire logic [7:0] rdAddr,
    output logic      [7:0] rdData
);
    // each register holds its address less 10h, so every count is known to the bench
    assign rdData = rdAddr - 8'h10;
endmodule : count_reg_file_model

// ===== verif/shift_unit_datapath_tb.sv
`timescale 1ns/100ps
// self-checking bench for the shift unit
module shift_unit_datapath_tb
    import shift_unit_pkg::*;
;
    logic        clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, res, q;
    logic        ack, rv, bsy;
    logic [7:0]  rAddr, rData, processor_status_word;
    int          badCount = 0, checked = 0;
    logic [7:0]  ops[9] = '{OP_WORD_LEFT, OP_BYTE_LEFT, OP_DWORD_LEFT, OP_WORD_LRIGHT,
        OP_BYTE_LRIGHT, OP_DWORD_LRIGHT, OP_WORD_ARIGHT, OP_BYTE_ARIGHT, OP_DWORD_ARIGHT};
    logic [7:0]  cnts[9] = '{8'h00, 8'h01, 8'h07, 8'h08, 8'h0f, 8'h10, 8'h20, 8'h2f, 8'h3c};

    always #20 clk = ~clk;

    shift_unit_datapath dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .regRdAddr(rAddr), .regRdData(rData), .resultData(res),
        .resultValid(rv), .pswOut(processor_status_word), .busy(bsy));
    count_reg_file_model regs (.rdAddr(rAddr), .rdData(rData));

    task automatic tallyAndFinish();
        if (badCount == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tallyAndFinish

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one classic cycle; waits on ack (only the watchdog ends that wait), then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    // reference shift, one step at a time; returns psw and result
    function automatic logic [39:0] model(input logic [7:0] op, input logic [4:0] n,
                                          input logic [31:0] d, input logic [7:0] p);
        int          w;
        logic        msb;
        logic [31:0] m, x;
        w = op[4] ? 8 : (op[2] ? 32 : 16);
        m = (w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
        x = d & m;
        msb = x[w-1];
        if (!op[0]) p[PSW_STICKY_BIT] = 1'b0;
        p[PSW_V_BIT] = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (!op[0] && i > 0 && p[PSW_C_BIT]) p[PSW_STICKY_BIT] = 1'b1;
            p[PSW_C_BIT] = op[0] ? x[w-1] : x[0];
            x = op[0] ? x << 1 : (x >> 1) | ((op[1] && msb) ? 32'h1 << (w - 1) : 32'h0);
            x = x & m;
            if (op[0] && x[w-1] != p[PSW_C_BIT]) p[PSW_V_BIT] = 1'b1;
        end
        p[PSW_Z_BIT] = (x == 32'h0);
        p[PSW_N_BIT] = (op[0] || op[1]) && x[w-1];
        return {p, x};
    endfunction : model

    // psw preset with trap, carry and sticky set, so keeping and clearing both show
    task automatic shift(input logic [7:0] op, input logic [7:0] cb, input logic [31:0] d);
        logic [39:0] e;
        int          t;
        e = model(op, cb < 8'h10 ? {1'b0, cb[3:0]} : 5'(cb - 8'h10), d, 8'h19);
        wb(1'b1, ADDR_OPCODE, {24'h0, op});
        wb(1'b1, ADDR_COUNT, {24'h0, cb});
        wb(1'b1, ADDR_OPERAND, d);
        wb(1'b1, ADDR_PSW, 32'h19);
        wb(1'b1, ADDR_CONTROL, 32'h1);
        t = 0;
        while (rv !== 1'b1 && t < 60) begin
            @(posedge clk);
            t++;
        end
        chk("result valid", 32'h1, {31'h0, rv});
        chk("result", e[31:0], res);
        chk("psw", {24'h0, e[39:32]}, {24'h0, processor_status_word});
    endtask : shift

    // status word and unit state straight after reset
    task automatic resetValues();
        wb(1'b0, ADDR_PSW, 32'h0);
        chk("psw reset", 32'h0, q);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("status reset", 32'h0, q);
    endtask : resetValues

    // non-shift opcode refused and flagged, flag cleared by control
    task automatic illegalOp();
        wb(1'b1, ADDR_OPCODE, 32'h0f);
        wb(1'b1, ADDR_CONTROL, 32'h1);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h2, q);
        wb(1'b1, ADDR_CONTROL, 32'h2);
        wb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h0, q);
    endtask : illegalOp

    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        resetValues();
        illegalOp();
        foreach (ops[i]) begin
            foreach (cnts[j]) begin
                shift(ops[i], cnts[j], 32'hc3a5_9681);
                shift(ops[i], cnts[j], 32'h4000_7f02);
            end
        end
        tallyAndFinish();
    end

    // watchdog, well past the expected run length
    initial begin
        #2_000_000;
        badCount++;
        tallyAndFinish();
    end
endmodule : shift_unit_datapath_tb
